// ==== sim/usb_phy_refclk_select_bench.sv ====
// Purpose: bench for the phy reference clock selector
// Assumes: axi4-lite master driven on rising aclk, one access at a time
// Notes:   table rows walk every frequency code, with the select bits varied from row to row
`timescale 1ns/1ns
`define CHK(n,e,v) begin checks++; if ((v) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %h got %h", n, e, v); end end
module usb_phy_refclk_select_bench;
   logic                 aclk, aresetn, awvalid, wvalid, bready;
   logic                 arvalid, rready, lock;
   logic                 awready, wready, bvalid, arready, rvalid, good;
   logic [7:0]           awaddr, araddr;
   logic [31:0]          wdata, rdata, rd;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp, rs, br;
   refclk_pkg::clk_cfg_t cfg;
   int                   error_cnt, checks;
   // row: lock, fs select, hs select, code, expected clock good
   // fs 1 beside hs 0 only at 48 mhz
   logic [7:0]           rows [17] = '{8'h80, 8'ha3, 8'he5, 8'hc7, 8'h89,
      8'hab, 8'hed, 8'hef, 8'h91, 8'hb3, 8'hf4, 8'hf6, 8'h98, 8'hba,
      8'hfc, 8'hfe, 8'h06};
////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   usb_phy_refclk_select dut_u (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (awaddr),
      .s_axi_awvalid (awvalid),
      .s_axi_awready (awready),
      .s_axi_wdata   (wdata),
      .s_axi_wstrb   (wstrb),
      .s_axi_wvalid  (wvalid),
      .s_axi_wready  (wready),
      .s_axi_bresp   (bresp),
      .s_axi_bvalid  (bvalid),
      .s_axi_bready  (bready),
      .s_axi_araddr  (araddr),
      .s_axi_arvalid (arvalid),
      .s_axi_arready (arready),
      .s_axi_rdata   (rdata),
      .s_axi_rresp   (rresp),
      .s_axi_rvalid  (rvalid),
      .s_axi_rready  (rready),
      .phy_pll_lock  (lock),
      .clk_cfg       (cfg),
      .phy_clock_good(good)
   );
////////////////////////////////////////////////////////////////////////////
   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      br = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axr

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
////////////////////////////////////////////////////////////////////////////
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, lock} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("cfg after reset", 6'h00, cfg)
      `CHK("good after reset", 1'b0, good)
      axr(refclk_pkg::OFF_CHIP_CFG_TWO);
      `CHK("cfg read reset", 32'h0, rd)
      // locked area must refuse a configuration write
      axw(refclk_pkg::OFF_CHIP_CFG_TWO, 32'h13);
      `CHK("locked resp", refclk_pkg::RESP_SLVERR, br)
      `CHK("locked cfg", 6'h00, cfg)
      axw(refclk_pkg::OFF_KEY_FIRST, refclk_pkg::KEY_FIRST_VALUE);
      axw(refclk_pkg::OFF_KEY_SECOND, refclk_pkg::KEY_SECOND_VALUE);
      axr(refclk_pkg::OFF_STATUS);
      `CHK("unlocked", 1'b1, rd[0])
      $display("test reset_and_lock done");
      for (int i = 0; i < 17; i++) begin
         lock <= rows[i][7];
         axw(refclk_pkg::OFF_CHIP_CFG_TWO, {26'h0, rows[i][6:1]});
         `CHK("write resp", refclk_pkg::RESP_OKAY, br)
         axr(refclk_pkg::OFF_CHIP_CFG_TWO);
         `CHK("read resp", refclk_pkg::RESP_OKAY, rs)
         `CHK("cfg read", {26'h0, rows[i][6:1]}, rd)
         `CHK("cfg out", rows[i][6:1], cfg)
         `CHK("clock good", rows[i][0], good)
         axr(refclk_pkg::OFF_STATUS);
         `CHK("status good", rows[i][0], rd[1])
      end
      $display("test table done");
      // unmapped place answers with an error and zero data
      axr(8'h10);
      `CHK("unmapped rresp", refclk_pkg::RESP_SLVERR, rs)
      `CHK("unmapped rdata", 32'h0, rd)
      axw(8'h10, 32'hffff_ffff);
      `CHK("unmapped bresp", refclk_pkg::RESP_SLVERR, br)
      // a wrong second key relocks and the selects stay put
      axw(refclk_pkg::OFF_KEY_SECOND, 32'h0);
      axw(refclk_pkg::OFF_CHIP_CFG_TWO, 32'h31);
      `CHK("relock resp", refclk_pkg::RESP_SLVERR, br)
      `CHK("relock cfg", rows[16][6:1], cfg)
      $display("test awkward done");
      // unlock again so reset has an unlocked state to clear
      axw(refclk_pkg::OFF_KEY_FIRST, refclk_pkg::KEY_FIRST_VALUE);
      axw(refclk_pkg::OFF_KEY_SECOND, refclk_pkg::KEY_SECOND_VALUE);
      axw(refclk_pkg::OFF_CHIP_CFG_TWO, 32'h31, 4'he);
      `CHK("strobe resp", refclk_pkg::RESP_OKAY, br)
      `CHK("strobe cfg", rows[16][6:1], cfg)
      lock <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("good before reset", 1'b1, good)
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("cfg mid reset", 6'h00, cfg)
      `CHK("good mid reset", 1'b0, good)
      axr(refclk_pkg::OFF_STATUS);
      `CHK("unlock after reset", 1'b0, rd[0])
      $display("test mid_reset done");
      close_out();
   end

   // whole run is well under a thousand cycles
   initial begin
      #200000;
      error_cnt++;
      $display("watchdog expired");
      close_out();
   end
endmodule : usb_phy_refclk_select_bench

// ==== verilog/refclk_pkg.sv ====
// Purpose: constants and carriers for the phy reference clock selector
// Assumes: 32-bit axi4-lite register access
// Notes:   offsets are byte addresses
package refclk_pkg;
   localparam logic [7:0]  OFF_CHIP_CFG_TWO   = 8'h00;
   localparam logic [7:0]  OFF_KEY_FIRST      = 8'h04;
   localparam logic [7:0]  OFF_KEY_SECOND     = 8'h08;
   localparam logic [7:0]  OFF_STATUS         = 8'h0c;
   localparam int          POS_FREQ_LSB       = 0;
   localparam int          POS_HS_SEL         = 4;
   localparam int          POS_FS_SEL         = 5;
   localparam int          POS_UNLOCKED       = 0;
   localparam int          POS_CLOCK_GOOD     = 1;
   localparam logic [31:0] KEY_FIRST_VALUE    = 32'h1234_5678;
   localparam logic [31:0] KEY_SECOND_VALUE   = 32'h9abc_def0;
   localparam logic [3:0]  RST_FREQ           = 4'h0;
   localparam logic        RST_HS_SEL         = 1'h0;
   localparam logic        RST_FS_SEL         = 1'h0;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;
   localparam logic [3:0]  FREQ_MIN_CODE      = 4'h1;
   localparam logic [3:0]  FREQ_MAX_CODE      = 4'h9;

   typedef struct packed {
      logic       fs_companion_clock_select;
      logic       hs_phy_clock_source_select;
      logic [3:0] phy_pll_input_frequency;
   } clk_cfg_t;
endpackage : refclk_pkg

// ==== verilog/usb_phy_refclk_select.sv ====
// Purpose: reference clock selection and phy pll frequency setup
// Assumes: single clock aclk, synchronous active-low reset
// Notes:   clock muxing is a select output for the analog mux cells
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module usb_phy_refclk_select (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      phy_pll_lock,
   output refclk_pkg::clk_cfg_t           clk_cfg,
   output logic                           phy_clock_good
);
   ////////////////////////////////////////////////////////////////////////
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       key_first_ok;
   logic       unlocked;
   logic       do_write;
   logic       freq_valid;

   // both channels captured independently, response once both are in
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_held       <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_held       <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= refclk_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         unique case (aw_addr)
            refclk_pkg::OFF_CHIP_CFG_TWO:
               s_axi_bresp <= unlocked ? refclk_pkg::RESP_OKAY
                                       : refclk_pkg::RESP_SLVERR;
            refclk_pkg::OFF_KEY_FIRST,
            refclk_pkg::OFF_KEY_SECOND,
            refclk_pkg::OFF_STATUS:
               s_axi_bresp <= refclk_pkg::RESP_OKAY;
            default:
               s_axi_bresp <= refclk_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // key unlock sequence
   // a wrong key relocks; partial strobes do not count as a key
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_first_ok <= 1'b0;
         unlocked     <= 1'b0;
      end else if (do_write && w_strb == 4'hf) begin
         if (aw_addr == refclk_pkg::OFF_KEY_FIRST) begin
            key_first_ok <= (w_data == refclk_pkg::KEY_FIRST_VALUE);
            if (w_data != refclk_pkg::KEY_FIRST_VALUE)
               unlocked <= 1'b0;
         end else if (aw_addr == refclk_pkg::OFF_KEY_SECOND) begin
            unlocked <= key_first_ok &&
                        (w_data == refclk_pkg::KEY_SECOND_VALUE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // select and frequency storage, only when unlocked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg.phy_pll_input_frequency    <= refclk_pkg::RST_FREQ;
         clk_cfg.hs_phy_clock_source_select <= refclk_pkg::RST_HS_SEL;
         clk_cfg.fs_companion_clock_select  <= refclk_pkg::RST_FS_SEL;
      end else if (do_write && unlocked && w_strb[0] &&
                   aw_addr == refclk_pkg::OFF_CHIP_CFG_TWO) begin
         clk_cfg.phy_pll_input_frequency    <=
            w_data[refclk_pkg::POS_FREQ_LSB +: 4];
         clk_cfg.hs_phy_clock_source_select <=
            w_data[refclk_pkg::POS_HS_SEL];
         clk_cfg.fs_companion_clock_select  <=
            w_data[refclk_pkg::POS_FS_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // supported code decode
   assign freq_valid =
      clk_cfg.phy_pll_input_frequency >= refclk_pkg::FREQ_MIN_CODE &&
      clk_cfg.phy_pll_input_frequency <= refclk_pkg::FREQ_MAX_CODE;

   // clock-good gated by code
   // lock alone is not trusted: a bad code means a wrong pll ratio
   always_ff @(posedge aclk) begin
      if (!aresetn)
         phy_clock_good <= 1'b0;
      else
         phy_clock_good <= freq_valid && phy_pll_lock;
   end

   ////////////////////////////////////////////////////////////////////////
   // bus logic is on aclk only; reads never depend on the phy clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= refclk_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= refclk_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            refclk_pkg::OFF_CHIP_CFG_TWO: begin
               s_axi_rdata[refclk_pkg::POS_FREQ_LSB +: 4] <=
                  clk_cfg.phy_pll_input_frequency;
               s_axi_rdata[refclk_pkg::POS_HS_SEL] <=
                  clk_cfg.hs_phy_clock_source_select;
               s_axi_rdata[refclk_pkg::POS_FS_SEL] <=
                  clk_cfg.fs_companion_clock_select;
            end
            refclk_pkg::OFF_STATUS: begin
               s_axi_rdata[refclk_pkg::POS_UNLOCKED]   <= unlocked;
               s_axi_rdata[refclk_pkg::POS_CLOCK_GOOD] <= phy_clock_good;
            end
            refclk_pkg::OFF_KEY_FIRST,
            refclk_pkg::OFF_KEY_SECOND: begin
            end
            default:
               s_axi_rresp <= refclk_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // good never with bad code
   a_good_needs_code: assert property (
      @(posedge aclk) disable iff (!aresetn)
      phy_clock_good |-> $past(freq_valid) && $past(phy_pll_lock))
      else $error("clock good without valid code and lock");

   a_locked_no_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && !unlocked && aw_addr == refclk_pkg::OFF_CHIP_CFG_TWO
      |=> $stable(clk_cfg) && s_axi_bresp == refclk_pkg::RESP_SLVERR)
      else $error("config changed while locked");

   a_hs_sel_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && unlocked && w_strb[0] &&
      aw_addr == refclk_pkg::OFF_CHIP_CFG_TWO
      |=> clk_cfg.hs_phy_clock_source_select ==
          $past(w_data[refclk_pkg::POS_HS_SEL]))
      else $error("hs select not stored");

   a_fs_sel_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && unlocked && w_strb[0] &&
      aw_addr == refclk_pkg::OFF_CHIP_CFG_TWO
      |=> clk_cfg.fs_companion_clock_select ==
          $past(w_data[refclk_pkg::POS_FS_SEL]))
      else $error("fs select not stored");

   a_code_gives_good: assert property (
      @(posedge aclk) disable iff (!aresetn)
      freq_valid && phy_pll_lock |=> phy_clock_good)
      else $error("valid code and lock did not give good");

   a_read_answer: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
      else $error("read not answered next cycle");

   a_cfg_only_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !do_write |=> $stable(clk_cfg))
      else $error("clock selection changed without a write");

   a_freq_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && unlocked && w_strb[0] &&
      aw_addr == refclk_pkg::OFF_CHIP_CFG_TWO
      |=> clk_cfg.phy_pll_input_frequency == $past(w_data[3:0]))
      else $error("frequency code not stored");
endmodule : usb_phy_refclk_select
